// file: dcad_decode.sv
/*
  Command, address and control input decoder of a DDR4 memory module.
  The link side samples the pins on the rising edge of the module clock and
  forwards each taken command by a toggle handshake to the core clock side,
  which also tracks the power state from a synchronised CKE.
  Assumes the host holds each command for one link clock period of 160 ns
  or more, well above the three core cycles the crossing needs.
*/
// Contract
// [R01] ACTIVATE takes row, READ/WRITE take column from address pins.
// [R02] MODE REGISTER SET takes its op-code from the address pins.
// [R03] A17 counts only on x4 parts; others force it to zero.
// [R04] A10 on READ/WRITE selects auto precharge, else bank stays open.
// [R05] PRECHARGE with A10 low closes one bank, high closes all.
// [R06] A12 low on READ/WRITE chops the burst, high runs it full.
// [R07] ACT_n low with CS_n gives ACTIVATE; RAS/CAS/WE become A16..A14.
// [R08] Bank inputs pick the bank within the group.
// [R09] Bank group and bank inputs pick the mode register for MRS.
// [R10] Bank group picks group; x16 uses only bit zero.
// [R11] Chip ID selects a stacked die; unused on x16 parts.
// [R12] Host drives second chip select and CKE for the second die; the decoder has one CKE input shared by both.
// [R13] All pins sampled on the rising edge of the module clock; RESET_N acts asynchronously and CKE also feeds the core synchroniser.
// [R14] CKE high enables clocks, buffers, drivers; low disables them.
// [R15] CKE low enters precharge power-down/self refresh or active power-down.
// [R16] Self refresh exit seen from CKE without the module clock.
// [R17] Host keeps CKE high through every read and write.
// [R18] Power-down keeps only clock, ODT, reset and CKE buffers on.
// [R19] Self refresh keeps only CKE and reset buffers on.
// [R20] Chip select high masks commands; it selects the rank.
// [R21] ACT_n high decodes other commands from RAS/CAS/WE.
// [R22] Pin reset is active low and asynchronous.
// [R23] With parity enabled in MR5, command and address parity is checked.
// [R24] RAS/CAS/WE encodings follow the standard command truth table.
`timescale 1ns/1ps
module dcad_decode #(
  parameter logic [1:0] ORG = dcad_pkg::DCAD_ORG_X8,
  parameter int STACK_LOG2 = 0
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CK_T,
  input wire logic RESET_N,
  input wire logic [1:0] CS_N,
  input wire logic CKE,
  input wire logic ACT_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [1:0] BG,
  input wire logic [1:0] BA,
  input wire logic [17:0] A,
  input wire logic [2:0] CID,
  input wire logic PARITY,
  output logic CMD_VALID,
  output logic [3:0] CMD_CODE,
  output logic [1:0] CMD_BG,
  output logic [1:0] CMD_BA,
  output logic [17:0] CMD_ADDR,
  output logic CMD_AUTO_PRE,
  output logic CMD_PRE_ALL,
  output logic CMD_CHOP,
  output logic [2:0] CMD_MR_SEL,
  output logic [2:0] CMD_CHIP_ID,
  output logic CMD_RANK,
  output logic [1:0] PWR_STATE,
  output logic CLK_EN,
  output logic CMD_BUF_EN,
  output logic CLK_BUF_EN,
  output logic DRV_EN
);

  // ==========================================================
  // Link side: pin decode on the module clock
  localparam logic [17:0] ADDR_MASK = (ORG == dcad_pkg::DCAD_ORG_X4) ? 18'h3FFFF : 18'h1FFFF;
  localparam logic [1:0] BG_MASK = (ORG == dcad_pkg::DCAD_ORG_X16) ? 2'h1 : 2'h3;
  localparam logic [2:0] CID_MASK = (ORG == dcad_pkg::DCAD_ORG_X16) ? 3'h0 :
                                    3'((8 >> (3 - STACK_LOG2)) - 1);

  logic cke_prev_q, cke_prev_d;
  logic par_en_q, par_en_d;
  logic [15:0] open_q, open_d;
  logic tog_q, tog_d;
  logic [3:0] w_code_q, w_code_d;
  logic [1:0] w_bg_q, w_bg_d;
  logic [1:0] w_ba_q, w_ba_d;
  logic [17:0] w_addr_q, w_addr_d;
  logic w_ap_q, w_ap_d;
  logic w_pall_q, w_pall_d;
  logic w_chop_q, w_chop_d;
  logic [2:0] w_mr_q, w_mr_d;
  logic [2:0] w_cid_q, w_cid_d;
  logic w_rank_q, w_rank_d;
  logic pd_open_q, pd_open_d;

  logic [17:0] a_m;
  logic [1:0] bg_m;
  logic [3:0] bidx;
  logic [2:0] enc;
  logic sel;
  logic par_err;
  logic take;
  logic [3:0] code;

  // Command decode and bank tracking
  always_comb begin
    a_m = A & ADDR_MASK; // [R03]
    bg_m = BG & BG_MASK; // [R10]
    bidx = {bg_m, BA}; // [R08] [R10]
    enc = {RAS_N, CAS_N, WE_N};
    sel = ~&CS_N; // [R20]
    par_err = par_en_q & (^{ACT_N, RAS_N, CAS_N, WE_N, bg_m, BA, a_m[16:0], PARITY}); // [R23]
    cke_prev_d = CKE;
    par_en_d = par_en_q;
    open_d = open_q;
    tog_d = tog_q;
    w_code_d = w_code_q;
    w_bg_d = w_bg_q;
    w_ba_d = w_ba_q;
    w_addr_d = w_addr_q;
    w_ap_d = w_ap_q;
    w_pall_d = w_pall_q;
    w_chop_d = w_chop_q;
    w_mr_d = w_mr_q;
    w_cid_d = w_cid_q;
    w_rank_d = w_rank_q;
    pd_open_d = pd_open_q;
    code = dcad_pkg::DCAD_CMD_NOP;
    // Commands need CKE high at the previous edge
    take = sel & cke_prev_q; // [R14] [R18] [R19] [R20]
    if (!ACT_N) begin
      code = dcad_pkg::DCAD_CMD_ACT; // [R07]
    end else begin
      unique case (enc) // [R21] [R24]
        dcad_pkg::DCAD_ENC_MRS: code = dcad_pkg::DCAD_CMD_MRS;
        dcad_pkg::DCAD_ENC_REF: code = dcad_pkg::DCAD_CMD_REF;
        dcad_pkg::DCAD_ENC_PRE: code = dcad_pkg::DCAD_CMD_PRE;
        dcad_pkg::DCAD_ENC_RFU: code = dcad_pkg::DCAD_CMD_RFU;
        dcad_pkg::DCAD_ENC_WR: code = dcad_pkg::DCAD_CMD_WR;
        dcad_pkg::DCAD_ENC_RD: code = dcad_pkg::DCAD_CMD_RD;
        dcad_pkg::DCAD_ENC_ZQ: code = dcad_pkg::DCAD_CMD_ZQ;
        dcad_pkg::DCAD_ENC_NOP: code = dcad_pkg::DCAD_CMD_NOP;
      endcase
    end
    if (cke_prev_q && !CKE) begin
      // CKE falling: self refresh if REFRESH with it, else power-down
      if (sel && ACT_N && !par_err && enc == dcad_pkg::DCAD_ENC_REF) begin
        code = dcad_pkg::DCAD_CMD_SRE; // [R15]
      end else begin
        code = dcad_pkg::DCAD_CMD_PDE; // [R15]
      end
      pd_open_d = |open_q; // [R15]
      take = 1'b1;
    end else if (take && par_err) begin
      code = dcad_pkg::DCAD_CMD_PERR; // [R23]
    end
    if (take && code != dcad_pkg::DCAD_CMD_NOP) begin
      tog_d = ~tog_q;
      w_code_d = code;
      w_bg_d = bg_m;
      w_ba_d = BA;
      w_addr_d = 18'h00000;
      w_ap_d = 1'b0;
      w_pall_d = 1'b0;
      w_chop_d = 1'b0;
      w_mr_d = 3'h0;
      w_cid_d = CID & CID_MASK; // [R11]
      w_rank_d = CS_N[0]; // [R20]
      unique case (code)
        dcad_pkg::DCAD_CMD_ACT: begin
          w_addr_d = {a_m[17], RAS_N, CAS_N, WE_N, a_m[13:0]}; // [R01] [R07]
          open_d[bidx] = 1'b1;
        end
        dcad_pkg::DCAD_CMD_RD, dcad_pkg::DCAD_CMD_WR: begin
          w_addr_d = {8'h00, a_m[9:0]}; // [R01]
          w_ap_d = a_m[dcad_pkg::DCAD_A10]; // [R04]
          w_chop_d = ~a_m[dcad_pkg::DCAD_A12]; // [R06]
          if (a_m[dcad_pkg::DCAD_A10]) begin
            open_d[bidx] = 1'b0; // [R04]
          end
        end
        dcad_pkg::DCAD_CMD_PRE: begin
          w_pall_d = a_m[dcad_pkg::DCAD_A10]; // [R05]
          if (a_m[dcad_pkg::DCAD_A10]) begin
            open_d = dcad_pkg::DCAD_OPEN_RST; // [R05]
          end else begin
            open_d[bidx] = 1'b0; // [R05] [R08]
          end
        end
        dcad_pkg::DCAD_CMD_MRS: begin
          w_addr_d = a_m; // [R02]
          w_mr_d = {bg_m[0], BA}; // [R09]
          if ({bg_m[0], BA} == dcad_pkg::DCAD_MR_PARITY) begin
            par_en_d = |a_m[2:0]; // [R23]
          end
        end
        default: begin
          w_addr_d = 18'h00000;
        end
      endcase
    end
  end

  // Link registers, pin reset asynchronous active low
  always_ff @(posedge CK_T or negedge RESET_N) begin // [R13] [R22]
    if (!RESET_N) begin
      cke_prev_q <= 1'b0;
      par_en_q <= 1'b0;
      open_q <= dcad_pkg::DCAD_OPEN_RST;
      tog_q <= 1'b0;
      w_code_q <= dcad_pkg::DCAD_CMD_NOP;
      w_bg_q <= 2'h0;
      w_ba_q <= 2'h0;
      w_addr_q <= 18'h00000;
      w_ap_q <= 1'b0;
      w_pall_q <= 1'b0;
      w_chop_q <= 1'b0;
      w_mr_q <= 3'h0;
      w_cid_q <= 3'h0;
      w_rank_q <= 1'b0;
      pd_open_q <= 1'b0;
    end else begin
      cke_prev_q <= cke_prev_d;
      par_en_q <= par_en_d;
      open_q <= open_d;
      tog_q <= tog_d;
      w_code_q <= w_code_d;
      w_bg_q <= w_bg_d;
      w_ba_q <= w_ba_d;
      w_addr_q <= w_addr_d;
      w_ap_q <= w_ap_d;
      w_pall_q <= w_pall_d;
      w_chop_q <= w_chop_d;
      w_mr_q <= w_mr_d;
      w_cid_q <= w_cid_d;
      w_rank_q <= w_rank_d;
      pd_open_q <= pd_open_d;
    end
  end

  // ==========================================================
  // Crossing into the core clock
  logic [1:0] sync_q;
  logic cke_s, tog_s;
  logic tog_seen_q, tog_seen_d;
  logic new_cmd;

  // CKE pin and command toggle, two flip-flops each
  dcad_sync #(.W(2)) u_sync (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .d({CKE, tog_q}),
    .q(sync_q)
  );

  // Toggle edge marks a stable command word
  always_comb begin
    cke_s = sync_q[1]; // [R16]
    tog_s = sync_q[0];
    new_cmd = tog_s ^ tog_seen_q;
    tog_seen_d = RESETN ? tog_s : 1'b0;
  end

  // ==========================================================
  // Core side: command outputs and power state
  dcad_pkg::dcad_pstate_t ps_q, ps_d;
  logic valid_d;
  logic [3:0] code_d;
  logic [1:0] bg_d, ba_d;
  logic [17:0] addr_d;
  logic ap_d, pall_d, chop_d, rank_d;
  logic [2:0] mr_d, cid_d;
  logic clk_en_d, cmd_buf_d, clk_buf_d, drv_d;

  // Next command word and power state
  always_comb begin
    valid_d = 1'b0;
    code_d = CMD_CODE;
    bg_d = CMD_BG;
    ba_d = CMD_BA;
    addr_d = CMD_ADDR;
    ap_d = CMD_AUTO_PRE;
    pall_d = CMD_PRE_ALL;
    chop_d = CMD_CHOP;
    mr_d = CMD_MR_SEL;
    cid_d = CMD_CHIP_ID;
    rank_d = CMD_RANK;
    ps_d = ps_q;
    if (new_cmd) begin
      valid_d = 1'b1;
      code_d = w_code_q;
      bg_d = w_bg_q;
      ba_d = w_ba_q;
      addr_d = w_addr_q;
      ap_d = w_ap_q;
      pall_d = w_pall_q;
      chop_d = w_chop_q;
      mr_d = w_mr_q;
      cid_d = w_cid_q;
      rank_d = w_rank_q;
    end
    unique case (ps_q)
      dcad_pkg::DCAD_PS_ACTIVE: begin
        if (new_cmd && w_code_q == dcad_pkg::DCAD_CMD_SRE) begin
          ps_d = dcad_pkg::DCAD_PS_SREF; // [R15]
        end else if (new_cmd && w_code_q == dcad_pkg::DCAD_CMD_PDE) begin
          ps_d = w_pd_sel(pd_open_q); // [R15]
        end
      end
      dcad_pkg::DCAD_PS_PD_PRE, dcad_pkg::DCAD_PS_PD_ACT, dcad_pkg::DCAD_PS_SREF: begin
        if (cke_s) begin
          ps_d = dcad_pkg::DCAD_PS_ACTIVE; // [R16]
        end
      end
    endcase
    if (!RESETN) begin
      valid_d = 1'b0;
      code_d = dcad_pkg::DCAD_CMD_NOP;
      ps_d = dcad_pkg::DCAD_PS_ACTIVE;
    end
    // Enables follow the next power state
    clk_en_d = (ps_d == dcad_pkg::DCAD_PS_ACTIVE); // [R14]
    drv_d = (ps_d == dcad_pkg::DCAD_PS_ACTIVE); // [R14]
    cmd_buf_d = (ps_d == dcad_pkg::DCAD_PS_ACTIVE); // [R18] [R19]
    clk_buf_d = (ps_d != dcad_pkg::DCAD_PS_SREF); // [R18] [R19]
  end

  function automatic dcad_pkg::dcad_pstate_t w_pd_sel(input logic open);
    w_pd_sel = open ? dcad_pkg::DCAD_PS_PD_ACT : dcad_pkg::DCAD_PS_PD_PRE;
  endfunction

  // Core registers
  always_ff @(posedge CORE_CLK) begin
    tog_seen_q <= tog_seen_d;
    ps_q <= ps_d;
    CMD_VALID <= valid_d;
    CMD_CODE <= code_d;
    CMD_BG <= bg_d;
    CMD_BA <= ba_d;
    CMD_ADDR <= addr_d;
    CMD_AUTO_PRE <= ap_d;
    CMD_PRE_ALL <= pall_d;
    CMD_CHOP <= chop_d;
    CMD_MR_SEL <= mr_d;
    CMD_CHIP_ID <= cid_d;
    CMD_RANK <= rank_d;
    PWR_STATE <= ps_d;
    CLK_EN <= clk_en_d;
    CMD_BUF_EN <= cmd_buf_d;
    CLK_BUF_EN <= clk_buf_d;
    DRV_EN <= drv_d;
  end

endmodule

// file: dcad_pkg.sv
/*
  Constants for the command and address decoder of a DDR4 memory module:
  command codes, organisation codes, field widths and reset values.
  Assumes a SystemVerilog compiler; used by the decoder, checker and testbench top files of the block.
*/
package dcad_pkg;

  // ==========================================================
  // Field widths
  localparam int DCAD_ADDR_W = 18;
  localparam int DCAD_CODE_W = 4;
  localparam int DCAD_NBANK = 16;

  // ==========================================================
  // Decoded command codes
  localparam logic [3:0] DCAD_CMD_NOP = 4'h0;
  localparam logic [3:0] DCAD_CMD_ACT = 4'h1;
  localparam logic [3:0] DCAD_CMD_RD = 4'h2;
  localparam logic [3:0] DCAD_CMD_WR = 4'h3;
  localparam logic [3:0] DCAD_CMD_PRE = 4'h4;
  localparam logic [3:0] DCAD_CMD_REF = 4'h5;
  localparam logic [3:0] DCAD_CMD_MRS = 4'h6;
  localparam logic [3:0] DCAD_CMD_ZQ = 4'h7;
  localparam logic [3:0] DCAD_CMD_SRE = 4'h8;
  localparam logic [3:0] DCAD_CMD_PDE = 4'h9;
  localparam logic [3:0] DCAD_CMD_RFU = 4'hA;
  localparam logic [3:0] DCAD_CMD_PERR = 4'hB;

  // ==========================================================
  // RAS_n, CAS_n, WE_n encodings with ACT_n high
  localparam logic [2:0] DCAD_ENC_MRS = 3'h0;
  localparam logic [2:0] DCAD_ENC_REF = 3'h1;
  localparam logic [2:0] DCAD_ENC_PRE = 3'h2;
  localparam logic [2:0] DCAD_ENC_RFU = 3'h3;
  localparam logic [2:0] DCAD_ENC_WR = 3'h4;
  localparam logic [2:0] DCAD_ENC_RD = 3'h5;
  localparam logic [2:0] DCAD_ENC_ZQ = 3'h6;
  localparam logic [2:0] DCAD_ENC_NOP = 3'h7;

  // ==========================================================
  // Organisation codes and mode register positions
  localparam logic [1:0] DCAD_ORG_X4 = 2'h0;
  localparam logic [1:0] DCAD_ORG_X8 = 2'h1;
  localparam logic [1:0] DCAD_ORG_X16 = 2'h2;
  localparam logic [2:0] DCAD_MR_PARITY = 3'h5;
  localparam int DCAD_A10 = 10;
  localparam int DCAD_A12 = 12;
  localparam int DCAD_A17 = 17;

  // ==========================================================
  // Power states; power-down entry and exit change one bit, self refresh entry and exit change two
  typedef enum logic [1:0] {
    DCAD_PS_ACTIVE = 2'h0,
    DCAD_PS_PD_PRE = 2'h1,
    DCAD_PS_SREF = 2'h3,
    DCAD_PS_PD_ACT = 2'h2
  } dcad_pstate_t;

  // ==========================================================
  // Reset values
  localparam logic [15:0] DCAD_OPEN_RST = 16'h0000;
  localparam logic [2:0] DCAD_SYNC_RST = 3'h0;

endpackage

// file: dcad_sync.sv
/*
  Two-stage synchroniser for a bundle of independent levels.
  Assumes each bit is a level that stays put for several destination cycles.
*/
`timescale 1ns/1ps
module dcad_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // Next values, reset synchronous active low
  always_comb begin
    meta_d = rst_n ? d : '0;
    q_d = rst_n ? meta_q : '0;
  end

  // First stage read only by second stage
  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    q <= q_d;
  end

endmodule

// file: dcad_decode_chk.sv
/*
  Checker for the command decoder: power state, enables and decoded fields.
  Assumes it is bound to dcad_decode and sees only that module's ports.
*/
`timescale 1ns/1ps
module dcad_decode_chk #(
  parameter logic [1:0] ORG = dcad_pkg::DCAD_ORG_X8,
  parameter int STACK_LOG2 = 0
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CKE,
  input wire logic CMD_VALID,
  input wire logic [3:0] CMD_CODE,
  input wire logic [17:0] CMD_ADDR,
  input wire logic [2:0] CMD_CHIP_ID,
  input wire logic [1:0] PWR_STATE,
  input wire logic CLK_EN,
  input wire logic CMD_BUF_EN,
  input wire logic CLK_BUF_EN,
  input wire logic DRV_EN
);
  // ==========================================================
  // Core clock and core reset for every property
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  // Asleep, then the clock enable seen high
  sequence s_wake;
    PWR_STATE == 2'h3 ##1 CKE;
  endsequence
  // A decoded event of one code
  sequence s_event(logic [3:0] c);
    CMD_VALID && CMD_CODE == c;
  endsequence

  // ==========================================================
  // Properties; the entry, column and A17 ones are built from s_event above
  property p_active_en;
    PWR_STATE == 2'h0 |-> CLK_EN && DRV_EN && CMD_BUF_EN && CLK_BUF_EN;
  endproperty
  property p_pd_bufs;
    PWR_STATE inside {2'h1, 2'h2} |-> CLK_BUF_EN && !CMD_BUF_EN && !CLK_EN && !DRV_EN;
  endproperty
  property p_sref_bufs;
    PWR_STATE == 2'h3 |-> !(CLK_BUF_EN || CMD_BUF_EN || CLK_EN || DRV_EN);
  endproperty
  property p_sre_enter;
    s_event(dcad_pkg::DCAD_CMD_SRE) |-> ##[0:1] PWR_STATE == 2'h3;
  endproperty
  property p_pde_enter;
    s_event(dcad_pkg::DCAD_CMD_PDE) |-> ##[0:1] PWR_STATE inside {2'h1, 2'h2};
  endproperty
  property p_col_width;
    (s_event(dcad_pkg::DCAD_CMD_RD) or s_event(dcad_pkg::DCAD_CMD_WR))
      |-> CMD_ADDR[17:10] == 8'h00;
  endproperty
  property p_a17_org;
    s_event(dcad_pkg::DCAD_CMD_ACT) ##0 (ORG != dcad_pkg::DCAD_ORG_X4) |-> !CMD_ADDR[17];
  endproperty

  // ==========================================================
  // Assertions
  a_valid_pulse: assert property (CMD_VALID |=> !CMD_VALID)
    else $error("valid pulse longer than one cycle");
  a_active_en: assert property (p_active_en)
    else $error("enables low while active");
  a_pd_bufs: assert property (p_pd_bufs)
    else $error("wrong buffers in power-down");
  a_sref_bufs: assert property (p_sref_bufs)
    else $error("buffer left on in self refresh");
  a_sref_exit: assert property (s_wake |-> ##[0:3] PWR_STATE == 2'h0)
    else $error("self refresh exit too slow");
  a_sre_enter: assert property (p_sre_enter)
    else $error("self refresh not entered");
  a_pde_enter: assert property (p_pde_enter)
    else $error("power-down not entered");
  a_col_width: assert property (p_col_width)
    else $error("column address too wide");
  a_a17_org: assert property (p_a17_org)
    else $error("top row bit kept on wide part");
  a_cid_mask: assert property (CMD_VALID |-> (CMD_CHIP_ID >> STACK_LOG2) == 3'h0)
    else $error("chip id outside stack");
endmodule

// file: dcad_host.sv
/*
  Host controller model driving the command, address and control pins.
  Assumes a free-running link clock that the bench may stop in self refresh.
*/
`timescale 1ns/1ps
module dcad_host (
  input wire logic ck,
  output logic reset_n,
  output logic cke,
  output logic [1:0] cs_n,
  output logic act_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic [17:0] a,
  output logic [2:0] cid,
  output logic parity
);
  logic pend, cke_v, bad_v, act_v;
  logic [2:0] rcw_v, cid_v;
  logic [1:0] cs_v, bg_v, ba_v;
  logic [17:0] a_v;

  // Pins quiet and in reset at time zero
  initial begin
    {pend, cke_v, reset_n, cke, act_n, ras_n, cas_n, we_n, parity} = 9'h0F;
    {cs_n, bg, ba, a, cid, cid_v} = {2'h3, 22'h0, 3'h3, 3'h3};
  end

  // ==========================================================
  // Present a command, or deselect and invert the other pins, on the falling link edge
  always @(negedge ck) begin
    cke <= cke_v;
    if (pend) begin
      {cs_n, act_n, ras_n, cas_n, we_n, bg, ba, a, cid} <=
        {cs_v, act_v, rcw_v, bg_v, ba_v, a_v, cid_v};
      parity <= (^{act_v, rcw_v, bg_v, ba_v, a_v[16:0]}) ^ bad_v;
      pend <= 1'b0;
    end else begin
      cs_n <= 2'h3;
      {act_n, ras_n, cas_n, we_n, bg, ba, a, cid, parity} <=
        ~{act_n, ras_n, cas_n, we_n, bg, ba, a, cid, parity};
    end
  end

  // One command held across one rising link edge
  task send(input logic act, input logic [2:0] rcw, input logic [1:0] cs, input logic [1:0] g,
            input logic [1:0] b, input logic [17:0] ad, input logic bad);
    {act_v, rcw_v, cs_v, bg_v, ba_v, a_v, bad_v, pend} = {act, rcw, cs, g, b, ad, bad, 1'b1};
    @(negedge ck);
    @(posedge ck);
  endtask

  // One parked edge with a chosen clock enable
  task idle_edge(input logic c);
    cke_v = c;
    @(negedge ck);
    @(posedge ck);
  endtask

  // Clock enable raised with no link clock
  task wake;
    cke_v = 1'b1;
    cke = 1'b1;
  endtask

  task release_rst;
    @(negedge ck);
    reset_n = 1'b1;
  endtask
endmodule

// file: dcad_decode_tb_top.sv
/*
  Testbench top for the command decoder: clocks, reset, scenarios, checker bind.
  Assumes dcad_pkg, dcad_decode, dcad_host and dcad_decode_chk are compiled first.
*/
`timescale 1ns/1ps
module dcad_decode_tb_top;
  logic core_clk, resetn, ck_t, ck_run, reset_n, cke, act_n, ras_n, cas_n, we_n, parity;
  logic cmd_valid, cmd_auto_pre, cmd_pre_all, cmd_chop, cmd_rank;
  logic clk_en, cmd_buf_en, clk_buf_en, drv_en;
  logic [1:0] cs_n, bg, ba, cmd_bg, cmd_ba, pwr_state;
  logic [17:0] a, cmd_addr;
  logic [2:0] cid, cmd_mr_sel, cmd_chip_id;
  logic [3:0] cmd_code;
  int num_errors = 0;
  int num_checks = 0;

  // ==========================================================
  // Core clock, and a link clock that can stop low
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    ck_t = 1'b0;
    ck_run = 1'b1;
    #7;
    forever begin
      #80;
      ck_t = ck_run ? ~ck_t : 1'b0;
    end
  end

  dcad_host host_u (.ck(ck_t), .reset_n(reset_n), .cke(cke), .cs_n(cs_n), .act_n(act_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .a(a), .cid(cid), .parity(parity));
  dcad_decode #(.ORG(dcad_pkg::DCAD_ORG_X8), .STACK_LOG2(1)) dut_u (.CORE_CLK(core_clk),
    .RESETN(resetn), .CK_T(ck_t), .RESET_N(reset_n), .CS_N(cs_n), .CKE(cke), .ACT_N(act_n),
    .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BG(bg), .BA(ba), .A(a), .CID(cid),
    .PARITY(parity), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_BG(cmd_bg),
    .CMD_BA(cmd_ba), .CMD_ADDR(cmd_addr), .CMD_AUTO_PRE(cmd_auto_pre), .CMD_PRE_ALL(cmd_pre_all),
    .CMD_CHOP(cmd_chop), .CMD_MR_SEL(cmd_mr_sel), .CMD_CHIP_ID(cmd_chip_id), .CMD_RANK(cmd_rank),
    .PWR_STATE(pwr_state), .CLK_EN(clk_en), .CMD_BUF_EN(cmd_buf_en), .CLK_BUF_EN(clk_buf_en),
    .DRV_EN(drv_en));

  // ==========================================================
  // Comparison, event wait and verdict
  task chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task get_cmd(input logic [3:0] code);
    int n;
    n = 0;
    while (cmd_valid !== 1'b1 && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    chk(18'(cmd_valid), 18'h1);
    chk(18'(cmd_code), 18'(code));
  endtask

  task close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task t_act;
    host_u.send(1'b0, 3'h5, 2'h2, 2'h2, 2'h1, 18'h21234, 1'b0);
    get_cmd(dcad_pkg::DCAD_CMD_ACT);
    chk(cmd_addr, {1'b0, 3'h5, 14'h1234});
    chk(18'(cmd_bg), 18'h2);
    chk(18'(cmd_ba), 18'h1);
    chk(18'(cmd_rank), 18'h0);
    chk(18'(cmd_chip_id), 18'h1);
  endtask

  task t_rdwr;
    logic [17:0] ad;
    for (int i = 0; i < 4; i++) begin
      ad = 18'h082A5 | (18'(i / 2) << 10) | (18'(i[0] ^ i[1]) << 12);
      host_u.cid_v = 3'(i + 2);
      host_u.send(1'b1, i[0] ? dcad_pkg::DCAD_ENC_WR : dcad_pkg::DCAD_ENC_RD, 2'h2, 2'h2, 2'h1,
                  ad, 1'b0);
      get_cmd(i[0] ? dcad_pkg::DCAD_CMD_WR : dcad_pkg::DCAD_CMD_RD);
      chk(18'(cmd_auto_pre), 18'(i / 2));
      chk(18'(cmd_chop), 18'(!(i[0] ^ i[1])));
      chk(cmd_addr, 18'h002A5);
      chk(18'(cmd_chip_id), 18'(i % 2));
    end
  endtask

  task t_pre;
    for (int j = 0; j < 2; j++) begin
      host_u.send(1'b1, dcad_pkg::DCAD_ENC_PRE, 2'h2, 2'h1, 2'h3, 18'(j) << 10, 1'b0);
      get_cmd(dcad_pkg::DCAD_CMD_PRE);
      chk(18'(cmd_pre_all), 18'(j));
      chk(18'({cmd_bg, cmd_ba}), 18'h7);
    end
  endtask

  // Refresh and calibration codes with the clock enable high
  task t_misc;
    host_u.send(1'b1, dcad_pkg::DCAD_ENC_REF, 2'h2, 2'h2, 2'h0, 18'h0, 1'b0);
    get_cmd(dcad_pkg::DCAD_CMD_REF);
    chk(18'(cmd_bg), 18'h2);
    host_u.send(1'b1, dcad_pkg::DCAD_ENC_ZQ, 2'h2, 2'h0, 2'h0, 18'h400, 1'b0);
    get_cmd(dcad_pkg::DCAD_CMD_ZQ);
    chk(cmd_addr, 18'h0);
  endtask

  task t_mask;
    logic seen;
    seen = 1'b0;
    host_u.send(1'b1, dcad_pkg::DCAD_ENC_RD, 2'h3, 2'h0, 2'h0, 18'h0, 1'b0);
    repeat (10) @(negedge core_clk) if (cmd_valid === 1'b1) seen = 1'b1;
    chk(18'(seen), 18'h0);
    host_u.send(1'b1, dcad_pkg::DCAD_ENC_RD, 2'h1, 2'h0, 2'h0, 18'h0, 1'b0);
    get_cmd(dcad_pkg::DCAD_CMD_RD);
    chk(18'(cmd_rank), 18'h1);
  endtask

  task t_parity;
    host_u.send(1'b1, dcad_pkg::DCAD_ENC_MRS, 2'h2, 2'h1, 2'h1, 18'h1, 1'b0);
    get_cmd(dcad_pkg::DCAD_CMD_MRS);
    chk(18'(cmd_mr_sel), 18'h5);
    chk(cmd_addr, 18'h1);
    host_u.send(1'b1, dcad_pkg::DCAD_ENC_RD, 2'h2, 2'h1, 2'h2, 18'h00C3, 1'b1);
    get_cmd(dcad_pkg::DCAD_CMD_PERR);
    host_u.send(1'b1, dcad_pkg::DCAD_ENC_RD, 2'h2, 2'h1, 2'h2, 18'h00C3, 1'b0);
    get_cmd(dcad_pkg::DCAD_CMD_RD);
    host_u.send(1'b1, dcad_pkg::DCAD_ENC_MRS, 2'h2, 2'h1, 2'h1, 18'h0, 1'b0);
    get_cmd(dcad_pkg::DCAD_CMD_MRS);
  endtask

  task t_pd;
    host_u.send(1'b0, 3'h0, 2'h2, 2'h0, 2'h0, 18'h0, 1'b0);
    get_cmd(dcad_pkg::DCAD_CMD_ACT);
    for (int k = 0; k < 2; k++) begin
      host_u.idle_edge(1'b0);
      get_cmd(dcad_pkg::DCAD_CMD_PDE);
      @(negedge core_clk);
      chk(18'(pwr_state), k ? 18'h1 : 18'h2);
      chk(18'({clk_buf_en, cmd_buf_en, clk_en}), 18'h4);
      host_u.idle_edge(1'b1);
      repeat (4) @(negedge core_clk);
      chk(18'(pwr_state), 18'h0);
      host_u.send(1'b1, dcad_pkg::DCAD_ENC_PRE, 2'h2, 2'h0, 2'h0, 18'h400, 1'b0);
      get_cmd(dcad_pkg::DCAD_CMD_PRE);
    end
  endtask

  task t_sref;
    host_u.cke_v = 1'b0;
    host_u.send(1'b1, dcad_pkg::DCAD_ENC_REF, 2'h2, 2'h0, 2'h0, 18'h0, 1'b0);
    get_cmd(dcad_pkg::DCAD_CMD_SRE);
    @(negedge core_clk);
    chk(18'(pwr_state), 18'h3);
    chk(18'({clk_buf_en, drv_en}), 18'h0);
    ck_run = 1'b0;
    repeat (10) @(negedge core_clk);
    host_u.wake();
    repeat (4) @(negedge core_clk);
    chk(18'(pwr_state), 18'h0);
    chk(18'({clk_en, clk_buf_en}), 18'h3);
    ck_run = 1'b1;
    host_u.idle_edge(1'b1);
  endtask

  // ==========================================================
  // Main sequence: both resets low together, then the scenarios
  initial begin
    resetn = 1'b0;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    host_u.release_rst();
    host_u.idle_edge(1'b1);
    host_u.idle_edge(1'b1);
    t_act();
    t_rdwr();
    t_pre();
    t_misc();
    t_mask();
    t_parity();
    t_pd();
    t_sref();
    close_out();
  end

  // Watchdog well beyond the expected run time
  initial begin
    #60000;
    num_errors++;
    close_out();
  end
endmodule

bind dcad_decode dcad_decode_chk #(.ORG(ORG), .STACK_LOG2(STACK_LOG2)) chk_u (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .CKE(CKE), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
  .CMD_ADDR(CMD_ADDR), .CMD_CHIP_ID(CMD_CHIP_ID), .PWR_STATE(PWR_STATE), .CLK_EN(CLK_EN),
  .CMD_BUF_EN(CMD_BUF_EN), .CLK_BUF_EN(CLK_BUF_EN), .DRV_EN(DRV_EN));
